// ===== verilog/bbt_cfg.svh
// Purpose: constants for the beam blanking and teach control block
// Assumes: 100 MHz clock, 16-beam receiver
// Notes: all counts and field positions live here
`ifndef BBT_CFG_SVH
`define BBT_CFG_SVH

// ****************************************
// geometry and timing
// ****************************************
`define BBT_BEAMS 16
`define BBT_CNT_W 5
`define BBT_MAX_AREAS 5'h0A
`define BBT_SIZE_TOL 5'h01
`define BBT_RR_MAX 5'h02
`define BBT_CLK_HZ 100000000
`define BBT_MS_CYCLES (`BBT_CLK_HZ / 1000)
`define BBT_MS_W 13
`define BBT_TEACH_MIN_MS 13'h0096
`define BBT_TEACH_MAX_MS 13'h0FA0
`define BBT_CTRL_WIN_MS 13'h01F4
`define BBT_BLINK_MS 13'h00FA

// ****************************************
// operating modes
// ****************************************
`define BBT_MODE_1 3'h1
`define BBT_MODE_2 3'h2
`define BBT_MODE_3 3'h3
`define BBT_MODE_4 3'h4
`define BBT_MODE_6 3'h6

// ****************************************
// register map and fields
// ****************************************
`define BBT_ADDR_CTRL 2'h0
`define BBT_ADDR_STAT 2'h1
`define BBT_ADDR_MASK 2'h2
`define BBT_ADDR_SIZE 2'h3
`define BBT_CTRL_RST 8'h01
`define BBT_F_MODE_HI 2
`define BBT_F_MODE_LO 0
`define BBT_F_FG1 3
`define BBT_F_FLOAT 4

`endif

// ===== verilog/bbt_pkg.sv
// Purpose: types for the beam blanking and teach control block
// Assumes: nothing
// Notes: states only; numbers sit in bbt_cfg.svh
package bbt_pkg;
	typedef enum logic [0:0] {TS_IDLE, TS_RUN} bbt_teach_st_t;
	typedef enum logic [1:0] {CS_WAIT, CS_ARMED, CS_WINDOW} bbt_ctl_st_t;
endpackage

// ===== verilog/bbt_blanking.sv
// Purpose: fixed/floating blanking, key teach, antivalent control, reduced resolution
// Assumes: scan results arrive as a one-cycle scan_done with the blocked beam map
// Notes: operator pins are synchronised; evaluation happens once per scan
// Overview of operation
// - fixed blanking of up to ten areas
// - fixed blanking without tolerance, modes 1-3
// - modes 4 and 6 widen areas one beam
// - valid key press starts teach, indicator flashes
// - second valid press ends teach, steady blue
// - teaching a free field clears blanking, indicator off
// - size drift over one beam aborts teach
// - floating blanking of up to ten areas
// - floating blanking switchable in mode 3
// - floating teach learns size and range
// - floating blanking forces reduced resolution
// - floating blanking extends response by one scan
// - complementary inputs inverted within half second
// - control switching only in modes 1 and 3
// - valid switch lights indicator, monitors areas
// - missing blanked objects switch outputs off
// - reduced resolution tolerates small objects
// - small objects not checked for presence
// - reduced resolution by mode 3 group one
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`include "bbt_cfg.svh"

module bbt_blanking #(
	parameter int MS_CYCLES = `BBT_MS_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register port
	input wire logic [1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// scan results
	input wire logic scan_done,
	input wire logic [`BBT_BEAMS-1:0] beam_blocked,
	// operator pins
	input wire logic teach_key,
	input wire logic ctrl_a,
	input wire logic ctrl_b,
	// outputs
	output logic safety_switch_output,
	output logic blanking_indicator,
	output logic teach_error
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [`BBT_CNT_W-1:0] popcnt(input logic [`BBT_BEAMS-1:0] v);
		logic [`BBT_CNT_W-1:0] c;
		c = '0;
		for (int i = 0; i < `BBT_BEAMS; i++) begin
			c = c + {{(`BBT_CNT_W-1){1'b0}}, v[i]};
		end
		return c;
	endfunction

	// ****************************************
	// registers and millisecond tick
	// ****************************************
	logic [7:0] ctrl_r;
	logic [2:0] mode;
	logic fg1, float_en, ms_tick;
	logic [31:0] div_r;

	// software settings: mode, function group one, floating enable
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_r <= `BBT_CTRL_RST;
		end else if (reg_wr && reg_addr == `BBT_ADDR_CTRL) begin
			ctrl_r <= reg_wdata[7:0];
		end
	end
	assign mode = ctrl_r[`BBT_F_MODE_HI:`BBT_F_MODE_LO];
	assign fg1 = ctrl_r[`BBT_F_FG1];
	assign float_en = ctrl_r[`BBT_F_FLOAT];

	// one-cycle tick per millisecond drives every slow timer
	always_ff @(posedge clk) begin
		if (!rst_b || ms_tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 32'h00000001;
		end
	end
	assign ms_tick = (div_r == 32'(MS_CYCLES - 1));

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] s1_r, s2_r;
	logic key_d_r;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
			key_d_r <= 1'b0;
		end else begin
			s1_r <= {ctrl_b, ctrl_a, teach_key};
			s2_r <= s1_r;
			key_d_r <= s2_r[0];
		end
	end

	// ****************************************
	// key press timing
	// ****************************************
	logic [`BBT_MS_W-1:0] press_ms_r;
	logic key_rel, press_valid;

	// counts press length; saturates just past the window so long holds stay invalid
	always_ff @(posedge clk) begin
		if (!rst_b || !s2_r[0]) begin
			press_ms_r <= '0;
		end else if (ms_tick && press_ms_r <= `BBT_TEACH_MAX_MS) begin
			press_ms_r <= press_ms_r + 13'h0001;
		end
	end
	assign key_rel = key_d_r && !s2_r[0];
	assign press_valid = key_rel && press_ms_r >= `BBT_TEACH_MIN_MS
		&& press_ms_r <= `BBT_TEACH_MAX_MS;

	// ****************************************
	// teach sequence
	// ****************************************
	bbt_pkg::bbt_teach_st_t teach_st_r;
	logic [`BBT_BEAMS-1:0] acc_r, mask_r;
	logic [`BBT_CNT_W-1:0] ref_r, size_r, scan_cnt, areas;
	logic ref_ok_r, u71_r, drift, teach_bad;

	assign scan_cnt = popcnt(beam_blocked);
	assign drift = ref_ok_r && (scan_cnt > ref_r + `BBT_SIZE_TOL
		|| ref_r > scan_cnt + `BBT_SIZE_TOL);
	// area starts are beams blocked whose lower neighbour is clear
	assign areas = popcnt(acc_r & ~{acc_r[`BBT_BEAMS-2:0], 1'b0});
	// too many areas or both sync beams blanked cannot be stored
	assign teach_bad = areas > `BBT_MAX_AREAS
		|| (acc_r[0] && acc_r[`BBT_BEAMS-1]);

	// teach state: start, learn range and size, end or abort
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			teach_st_r <= bbt_pkg::TS_IDLE;
			acc_r <= '0;
			mask_r <= '0;
			ref_r <= '0;
			size_r <= '0;
			ref_ok_r <= 1'b0;
			u71_r <= 1'b0;
		end else begin
			unique case (teach_st_r)
				bbt_pkg::TS_IDLE: begin
					if (press_valid) begin
						teach_st_r <= bbt_pkg::TS_RUN;
						acc_r <= '0;
						ref_ok_r <= 1'b0;
						u71_r <= 1'b0;
					end
				end
				bbt_pkg::TS_RUN: begin
					if (scan_done && drift) begin
						teach_st_r <= bbt_pkg::TS_IDLE;
						u71_r <= 1'b1;
					end else if (press_valid) begin
						teach_st_r <= bbt_pkg::TS_IDLE;
						if (teach_bad) begin
							u71_r <= 1'b1;
						end else begin
							mask_r <= acc_r;
							size_r <= ref_r;
						end
					end else if (scan_done) begin
						// union of all scans is the movement range
						acc_r <= acc_r | beam_blocked;
						if (!ref_ok_r) begin
							ref_r <= scan_cnt;
							ref_ok_r <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	// ****************************************
	// antivalent control inputs
	// ****************************************
	bbt_pkg::bbt_ctl_st_t ctl_st_r;
	logic [`BBT_MS_W-1:0] win_ms_r;
	logic lvl_a_r, blank_on_r, ctl_mode, ctl_ok, a_s, b_s;

	assign a_s = s2_r[1];
	assign b_s = s2_r[2];
	assign ctl_mode = mode == `BBT_MODE_1 || mode == `BBT_MODE_3;

	// a toggle needs complementary levels, then both inverted inside the window
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctl_st_r <= bbt_pkg::CS_WAIT;
			lvl_a_r <= 1'b0;
			win_ms_r <= '0;
		end else begin
			unique case (ctl_st_r)
				bbt_pkg::CS_WAIT: begin
					if (a_s != b_s) begin
						ctl_st_r <= bbt_pkg::CS_ARMED;
						lvl_a_r <= a_s;
					end
				end
				bbt_pkg::CS_ARMED: begin
					win_ms_r <= '0;
					if (a_s != lvl_a_r && b_s == lvl_a_r) begin
						lvl_a_r <= a_s;
					end else if (a_s != lvl_a_r || b_s == lvl_a_r) begin
						ctl_st_r <= bbt_pkg::CS_WINDOW;
					end
				end
				bbt_pkg::CS_WINDOW: begin
					if (a_s != lvl_a_r && b_s == lvl_a_r) begin
						ctl_st_r <= bbt_pkg::CS_ARMED;
						lvl_a_r <= a_s;
					end else if (a_s == lvl_a_r && b_s != lvl_a_r) begin
						ctl_st_r <= bbt_pkg::CS_ARMED;
					end else if (win_ms_r >= `BBT_CTRL_WIN_MS) begin
						ctl_st_r <= bbt_pkg::CS_WAIT;
					end else if (ms_tick) begin
						win_ms_r <= win_ms_r + 13'h0001;
					end
				end
			endcase
		end
	end
	// a full inversion seen directly or inside the window is a valid sequence
	assign ctl_ok = (ctl_st_r != bbt_pkg::CS_WAIT) && a_s != lvl_a_r
		&& b_s == lvl_a_r && (ctl_st_r == bbt_pkg::CS_ARMED
		|| win_ms_r < `BBT_CTRL_WIN_MS);

	// blanking switch state; outside modes 1 and 3 it is held on
	always_ff @(posedge clk) begin
		if (!rst_b || !ctl_mode) begin
			blank_on_r <= 1'b1;
		end else if (ctl_ok) begin
			blank_on_r <= !blank_on_r;
		end
	end

	// ****************************************
	// scan evaluation
	// ****************************************
	logic tol, float_act, rr_act, blank_act, present, field_ok, scan_ok;
	logic [`BBT_BEAMS-1:0] area, in_area, outside;
	logic pend_r, safe_r;

	assign tol = mode == `BBT_MODE_4 || mode == `BBT_MODE_6;
	assign float_act = mode == `BBT_MODE_3 && float_en && blank_on_r;
	assign rr_act = (mode == `BBT_MODE_3 && fg1) || float_act;
	assign blank_act = blank_on_r && |mask_r && teach_st_r == bbt_pkg::TS_IDLE;
	// tolerance widens each area one beam each side
	assign area = tol ? (mask_r | {mask_r[`BBT_BEAMS-2:0], 1'b0}
		| {1'b0, mask_r[`BBT_BEAMS-1:1]}) : mask_r;
	assign in_area = beam_blocked & area;
	assign outside = blank_act ? (beam_blocked & ~area) : beam_blocked;
	// fixed areas without tolerance need every beam blocked; tolerant or floating areas need any
	assign present = !blank_act || ((tol || float_act) ? |in_area
		: in_area == mask_r);
	// small objects outside areas pass without presence check
	assign field_ok = outside == '0
		|| (rr_act && popcnt(outside) <= `BBT_RR_MAX);
	assign scan_ok = present && field_ok;

	// output decision per scan; floating blanking allows one extra scan
	always_ff @(posedge clk) begin
		if (!rst_b || teach_st_r == bbt_pkg::TS_RUN) begin
			safe_r <= 1'b0;
			pend_r <= 1'b0;
		end else if (scan_done) begin
			if (scan_ok) begin
				safe_r <= 1'b1;
				pend_r <= 1'b0;
			end else if (float_act && !pend_r && safe_r) begin
				pend_r <= 1'b1;
			end else begin
				safe_r <= 1'b0;
				pend_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// indicator
	// ****************************************
	logic [`BBT_MS_W-1:0] blink_ms_r;
	logic blink_r, ind_r;

	// flash rate is a free-running half period
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			blink_ms_r <= '0;
			blink_r <= 1'b0;
		end else if (ms_tick) begin
			if (blink_ms_r >= `BBT_BLINK_MS - 13'h0001) begin
				blink_ms_r <= '0;
				blink_r <= !blink_r;
			end else begin
				blink_ms_r <= blink_ms_r + 13'h0001;
			end
		end
	end

	// flashing while teaching, steady while areas are monitored, else dark
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ind_r <= 1'b0;
		end else if (teach_st_r == bbt_pkg::TS_RUN) begin
			ind_r <= blink_r;
		end else begin
			ind_r <= blank_act;
		end
	end

	assign safety_switch_output = safe_r;
	assign blanking_indicator = ind_r;
	assign teach_error = u71_r;

	// ****************************************
	// register read
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`BBT_ADDR_CTRL: reg_rdata <= {8'h00, ctrl_r};
				`BBT_ADDR_STAT: reg_rdata <= {8'h00, areas[3:0], blank_on_r,
					safe_r, u71_r, teach_st_r == bbt_pkg::TS_RUN};
				`BBT_ADDR_MASK: reg_rdata <= mask_r;
				`BBT_ADDR_SIZE: reg_rdata <= {11'h000, size_r};
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence idle_press_s;
		teach_st_r == bbt_pkg::TS_IDLE && press_valid;
	endsequence
	sequence run_end_s;
		teach_st_r == bbt_pkg::TS_RUN && press_valid && !(scan_done && drift);
	endsequence

	teach_start_a: assert property (idle_press_s |=> teach_st_r == bbt_pkg::TS_RUN
		##1 blanking_indicator == $past(blink_r))
		else $error("teach did not start on valid press");
	teach_end_a: assert property (run_end_s and (!teach_bad && acc_r != '0)
		|=> teach_st_r == bbt_pkg::TS_IDLE ##1 blanking_indicator == blank_act)
		else $error("teach did not end with stored areas");
	free_field_a: assert property (run_end_s and acc_r == '0
		|=> mask_r == '0 ##1 !blanking_indicator)
		else $error("free field teach left blanking");
	size_drift_a: assert property (teach_st_r == bbt_pkg::TS_RUN && scan_done && drift
		|=> teach_error && teach_st_r == bbt_pkg::TS_IDLE)
		else $error("size drift did not abort teach");
	bad_press_a: assert property (teach_st_r == bbt_pkg::TS_IDLE && key_rel
		&& press_ms_r < `BBT_TEACH_MIN_MS |=> teach_st_r == bbt_pkg::TS_IDLE)
		else $error("short press changed teach state");
	ctl_lock_a: assert property (!ctl_mode |=> blank_on_r)
		else $error("blanking switched outside modes 1 and 3");
	ctl_toggle_a: assert property (ctl_mode && ctl_st_r == bbt_pkg::CS_WINDOW
		&& win_ms_r >= `BBT_CTRL_WIN_MS |=> $stable(blank_on_r))
		else $error("late inversion toggled blanking");
	absent_off_a: assert property (scan_done && blank_act && !present && !float_act
		|=> !safety_switch_output)
		else $error("outputs on with blanked object absent");
	float_delay_a: assert property (scan_done && float_act && !scan_ok && safe_r && !pend_r
		&& teach_st_r == bbt_pkg::TS_IDLE |=> safety_switch_output && pend_r)
		else $error("floating blanking did not extend response");
	float_rr_a: assert property (float_act |-> rr_act)
		else $error("floating blanking without reduced resolution");

endmodule

// ===== verif/bbt_operator.sv
// Purpose: operator side model: teach key switch and two-level control switch
// Assumes: MS clock cycles make one millisecond
// Notes: pins move only right after a rising edge; no handshake, the pins are async
`timescale 1ns/10ps
module bbt_operator #(
	parameter int MS = 10
) (
	// clock
	input wire logic clk,
	// operator pins
	output logic teach_key,
	output logic ctrl_a,
	output logic ctrl_b
);
	// ****************************************
	// pin stimulus
	// ****************************************
	// control pins start antivalent, as a two-level switch always leaves them
	initial begin
		teach_key = 1'b0;
		ctrl_a = 1'b0;
		ctrl_b = 1'b1;
	end
	// wait n milliseconds of clock
	task automatic hold(input int n);
		repeat (n * MS) @(posedge clk);
	endtask
	// key held n ms then let go; a gap follows so presses never merge
	task automatic press(input int n);
		@(posedge clk);
		teach_key <= 1'b1;
		hold(n);
		teach_key <= 1'b0;
		hold(50);
	endtask
	// invert both control pins, the second one gap ms after the first
	task automatic flip(input int gap);
		@(posedge clk);
		ctrl_a <= ~ctrl_a;
		hold(gap);
		ctrl_b <= ~ctrl_b;
		hold(20);
	endtask
endmodule

// ===== verif/beam_blanking_teach_control_test.sv
// Purpose: self-checking bench for the blanking and teach block
// Assumes: MS_CYCLES of 10, so one millisecond is ten clocks
// Notes: one task per scenario; scenarios run in order and share the taught mask
`timescale 1ns/10ps
`include "bbt_cfg.svh"
module beam_blanking_teach_control_test;
	logic clk;
	logic rst_b;
	logic [1:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic scan_done;
	logic [`BBT_BEAMS-1:0] beam_blocked;
	logic [15:0] reg_rdata;
	logic teach_key;
	logic ctrl_a;
	logic ctrl_b;
	logic safety_switch_output;
	logic blanking_indicator;
	logic teach_error;
	logic [15:0] d;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	// ****************************************
	// clock, instances, timeout
	// ****************************************
	always #5 clk = ~clk;
	bbt_operator #(.MS(10)) op(.clk(clk), .teach_key(teach_key), .ctrl_a(ctrl_a),
		.ctrl_b(ctrl_b));
	bbt_blanking #(.MS_CYCLES(10)) dut(.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.scan_done(scan_done), .beam_blocked(beam_blocked), .teach_key(teach_key),
		.ctrl_a(ctrl_a), .ctrl_b(ctrl_b), .safety_switch_output(safety_switch_output),
		.blanking_indicator(blanking_indicator), .teach_error(teach_error));
	// the whole run needs about 37000 clocks; the cap leaves margin before a hang is called
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			complete_run();
		end
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic stat(input logic [15:0] m, input logic [15:0] exp);
		rd(`BBT_ADDR_STAT);
		chk(d & m, exp);
	endtask
	// one scan pulse, then the settled safety output
	task automatic scan(input logic [15:0] m, input logic exp);
		@(posedge clk);
		scan_done <= 1'b1;
		beam_blocked <= m;
		@(posedge clk);
		scan_done <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk({15'h0, safety_switch_output}, {15'h0, exp});
	endtask
	task automatic teach_start();
		op.press(200);
		stat(16'h0001, 16'h0001);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		rd(`BBT_ADDR_CTRL);
		chk(d, 16'h0001);
		wr(`BBT_ADDR_STAT, 16'hFFFF);
		stat(16'h000B, 16'h0008);
	endtask
	// stray beams: refused in mode 1, tolerated up to two in mode 3 group one
	task automatic t_reduced();
		scan(16'h0300, 1'b0);
		wr(`BBT_ADDR_CTRL, 16'h000B);
		scan(16'h0300, 1'b1);
		scan(16'h0700, 1'b0);
		scan(16'h0100, 1'b1);
		scan(16'h0000, 1'b1);
		wr(`BBT_ADDR_CTRL, 16'h0001);
	endtask
	task automatic t_short();
		op.press(50);
		stat(16'h0001, 16'h0000);
	endtask
	// one area on beams 3-4, both sync beams and spacing left free
	task automatic t_fixed();
		int n;
		logic p;
		teach_start();
		scan(16'h0018, 1'b0);
		n = 0;
		p = blanking_indicator;
		repeat (6000) begin
			// sample away from the launching edge of the indicator flop
			@(negedge clk);
			if (blanking_indicator !== p) n++;
			p = blanking_indicator;
		end
		chk({15'h0, n inside {2, 3}}, 16'h0001);
		scan(16'h0018, 1'b0);
		op.press(200);
		chk({15'h0, blanking_indicator}, 16'h0001);
		stat(16'h00F3, 16'h0010);
		rd(`BBT_ADDR_MASK);
		chk(d, 16'h0018);
		scan(16'h0018, 1'b1);
		scan(16'h0000, 1'b0);
		scan(16'h0008, 1'b0);
		wr(`BBT_ADDR_CTRL, 16'h0004);
		scan(16'h0020, 1'b1);
		scan(16'h0040, 1'b0);
		wr(`BBT_ADDR_CTRL, 16'h0001);
		scan(16'h0020, 1'b0);
	endtask
	// switch state toggles only on a prompt double inversion
	task automatic t_ctrl();
		op.flip(100);
		stat(16'h0008, 16'h0000);
		scan(16'h0018, 1'b0);
		op.flip(600);
		stat(16'h0008, 16'h0000);
		op.flip(100);
		stat(16'h0008, 16'h0008);
		chk({15'h0, blanking_indicator}, 16'h0001);
		scan(16'h0018, 1'b1);
		op.flip(100);
		wr(`BBT_ADDR_CTRL, 16'h0002);
		stat(16'h0008, 16'h0008);
		wr(`BBT_ADDR_CTRL, 16'h0001);
	endtask
	// object grows from two beams to four while teaching
	task automatic t_err();
		teach_start();
		scan(16'h0018, 1'b0);
		scan(16'h0078, 1'b0);
		chk({15'h0, teach_error}, 16'h0001);
		stat(16'h0003, 16'h0002);
		rd(`BBT_ADDR_MASK);
		chk(d, 16'h0018);
	endtask
	task automatic t_clear();
		teach_start();
		chk({15'h0, teach_error}, 16'h0000);
		scan(16'h0000, 1'b0);
		op.press(200);
		chk({15'h0, blanking_indicator}, 16'h0000);
		rd(`BBT_ADDR_MASK);
		chk(d, 16'h0000);
		scan(16'h0000, 1'b1);
	endtask
	// floating area on beams 3-5 learnt from a two-beam object that moves
	task automatic t_float();
		wr(`BBT_ADDR_CTRL, 16'h0013);
		teach_start();
		scan(16'h0018, 1'b0);
		scan(16'h0030, 1'b0);
		op.press(200);
		rd(`BBT_ADDR_MASK);
		chk(d, 16'h0038);
		rd(`BBT_ADDR_SIZE);
		chk(d, 16'h0002);
		scan(16'h0030, 1'b1);
		scan(16'h0000, 1'b1);
		scan(16'h0000, 1'b0);
		scan(16'h0318, 1'b1);
		op.flip(100);
		scan(16'h0010, 1'b0);
		chk({15'h0, blanking_indicator}, 16'h0000);
		op.flip(100);
		scan(16'h0010, 1'b1);
		wr(`BBT_ADDR_CTRL, 16'h0001);
	endtask
	task automatic complete_run();
		$display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		reg_addr = 2'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		scan_done = 1'b0;
		beam_blocked = 16'h0000;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_reduced();
		t_short();
		t_fixed();
		t_ctrl();
		t_err();
		t_clear();
		t_float();
		complete_run();
	end
endmodule
